//--- pkg/rcc_pkg.sv
package rcc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] RUN_CLOCK_CONFIG_OFFSET = 8'h60;
    localparam logic [31:0] RUN_CLOCK_CONFIG_RESET = 32'h07a0_3ad1;
    localparam int AUTO_GATING_BIT = 27;
    localparam int DIV_HI = 26;
    localparam int DIV_LO = 23;
    localparam int DIV_SEL_BIT = 22;
    localparam int PLL_POWER_DOWN_BIT = 13;
    localparam int OEN_BIT = 12;
    localparam int BYPASS_BIT = 11;
    localparam int LOW_HI = 10;
    localparam int LOW_LO = 0;
    localparam logic [3:0] DIV_RESET = 4'hf;
    localparam logic [3:0] MIN_DIV_PLL = 4'h3;
    localparam logic [3:0] DIV_RESERVED = 4'h0;
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_DEEP = 2'h2;
    localparam int GATE_W = 32;
endpackage

//--- core/clock_divider.sv
`timescale 1ns/1ps
module clock_divider (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic [3:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } div_state_t;
    div_state_t state_ff;
    div_state_t nxt_state;

    // Counts to divisor then wraps, giving one enable pulse per divisor+1 source cycles.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (!enable) begin
            nxt_state.cnt = 4'h0;
        end else if (state_ff.cnt >= divisor) begin
            nxt_state.cnt = 4'h0;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tick = state_ff.tick;
endmodule // clock_divider

//--- core/run_clock_config_upper_fields.sv
`timescale 1ns/1ps
module run_clock_config_upper_fields (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [1:0] power_mode,
    input wire logic [31:0] run_gating_regs,
    input wire logic [31:0] sleep_gating_regs,
    input wire logic [31:0] deep_sleep_gating_regs,
    input wire logic osc_tick,
    input wire logic pll_tick,
    output logic [31:0] periph_clock_enable,
    output logic sys_clock_tick,
    output logic pll_power_down,
    output logic pll_output_enable_n,
    output logic [3:0] effective_divisor,
    output logic divider_active
);
    typedef struct packed {
        logic auto_sleep_gating;
        logic [3:0] system_divisor;
        logic divider_select;
        logic pll_power_down;
        logic pll_output_enable_n;
        logic bypass;
        logic [10:0] low_bits;
        logic [31:0] rdata;
        logic [31:0] gate;
        logic sys_tick;
        logic [3:0] eff_div;
        logic div_active;
    } cfg_state_t;
    cfg_state_t state_ff;
    cfg_state_t nxt_state;
    logic div_tick;
    logic src_tick;
    logic pll_used;
    logic use_div;
    logic [3:0] div_now;

    // The floor is applied on the way out, so the stored code survives a return to bypass.
    function automatic logic [3:0] floor_div(input logic [3:0] code, input logic on_pll);
        if (on_pll && code < rcc_pkg::MIN_DIV_PLL) begin
            floor_div = rcc_pkg::MIN_DIV_PLL;
        end else begin
            floor_div = code;
        end
    endfunction

    assign pll_used = !state_ff.bypass;
    assign use_div = state_ff.divider_select || pll_used;
    assign div_now = floor_div(state_ff.system_divisor, pll_used);
    assign src_tick = state_ff.bypass ? osc_tick : (pll_tick && !state_ff.pll_output_enable_n);

    clock_divider u_div (
        .clock(clock),
        .reset(reset),
        .enable(use_div && src_tick),
        .divisor(div_now),
        .tick(div_tick)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = 32'h0000_0000;
        if (wr && addr == rcc_pkg::RUN_CLOCK_CONFIG_OFFSET) begin
            nxt_state.auto_sleep_gating = wdata[rcc_pkg::AUTO_GATING_BIT];
            nxt_state.system_divisor = wdata[rcc_pkg::DIV_HI:rcc_pkg::DIV_LO];
            nxt_state.divider_select = wdata[rcc_pkg::DIV_SEL_BIT];
            nxt_state.pll_power_down = wdata[rcc_pkg::PLL_POWER_DOWN_BIT];
            nxt_state.pll_output_enable_n = wdata[rcc_pkg::OEN_BIT];
            nxt_state.bypass = wdata[rcc_pkg::BYPASS_BIT];
            nxt_state.low_bits = wdata[rcc_pkg::LOW_HI:rcc_pkg::LOW_LO];
        end
        if (rd && addr == rcc_pkg::RUN_CLOCK_CONFIG_OFFSET) begin
            // Reserved bits read zero because rdata starts cleared and only the defined fields are filled in.
            nxt_state.rdata[rcc_pkg::AUTO_GATING_BIT] = state_ff.auto_sleep_gating;
            nxt_state.rdata[rcc_pkg::DIV_HI:rcc_pkg::DIV_LO] = div_now;
            nxt_state.rdata[rcc_pkg::DIV_SEL_BIT] = state_ff.divider_select;
            nxt_state.rdata[rcc_pkg::PLL_POWER_DOWN_BIT] = state_ff.pll_power_down;
            nxt_state.rdata[rcc_pkg::OEN_BIT] = state_ff.pll_output_enable_n;
            nxt_state.rdata[rcc_pkg::BYPASS_BIT] = state_ff.bypass;
            nxt_state.rdata[rcc_pkg::LOW_HI:rcc_pkg::LOW_LO] = state_ff.low_bits;
        end
        if (power_mode == rcc_pkg::MODE_SLEEP && state_ff.auto_sleep_gating) begin
            nxt_state.gate = sleep_gating_regs;
        end else if (power_mode == rcc_pkg::MODE_DEEP && state_ff.auto_sleep_gating) begin
            nxt_state.gate = deep_sleep_gating_regs;
        end else begin
            nxt_state.gate = run_gating_regs;
        end
        nxt_state.sys_tick = use_div ? div_tick : osc_tick;
        nxt_state.eff_div = div_now;
        nxt_state.div_active = use_div;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= '0;
            state_ff.auto_sleep_gating <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::AUTO_GATING_BIT];
            state_ff.system_divisor <= rcc_pkg::DIV_RESET;
            state_ff.divider_select <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::DIV_SEL_BIT];
            state_ff.pll_power_down <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::PLL_POWER_DOWN_BIT];
            state_ff.pll_output_enable_n <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::OEN_BIT];
            state_ff.bypass <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::BYPASS_BIT];
            state_ff.low_bits <= rcc_pkg::RUN_CLOCK_CONFIG_RESET[rcc_pkg::LOW_HI:rcc_pkg::LOW_LO];
            state_ff.eff_div <= rcc_pkg::DIV_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata = state_ff.rdata;
    assign periph_clock_enable = state_ff.gate;
    assign sys_clock_tick = state_ff.sys_tick;
    assign pll_power_down = state_ff.pll_power_down;
    assign pll_output_enable_n = state_ff.pll_output_enable_n;
    assign effective_divisor = state_ff.eff_div;
    assign divider_active = state_ff.div_active;
endmodule // run_clock_config_upper_fields

//--- verification/clk_cfg_chk.sv
`timescale 1ns/1ps
module clk_cfg_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [1:0] power_mode,
    input wire logic [31:0] run_gating_regs,
    input wire logic [31:0] sleep_gating_regs,
    input wire logic [31:0] deep_sleep_gating_regs,
    input wire logic [31:0] periph_clock_enable,
    input wire logic pll_power_down,
    input wire logic pll_output_enable_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // A write right after the read would make the read value stale, so it is excluded.
    sequence cfg_read;
        rd && addr == 8'h60 ##1 !wr;
    endsequence
    a_run_gating: assert property (power_mode == 2'h0 |=> periph_clock_enable == $past(run_gating_regs))
        else $error("run gating not used");
    a_sleep_manual: assert property (cfg_read ##0 !rdata[27] && power_mode == 2'h1
        |=> periph_clock_enable == $past(run_gating_regs)) else $error("sleep ignored run gating");
    a_sleep_auto: assert property (cfg_read ##0 rdata[27] && power_mode == 2'h1
        |=> periph_clock_enable == $past(sleep_gating_regs)) else $error("sleep gating not used");
    a_deep_auto: assert property (cfg_read ##0 rdata[27] && power_mode == 2'h2
        |=> periph_clock_enable == $past(deep_sleep_gating_regs)) else $error("deep gating not used");
    a_reserved_zero: assert property (rd && addr == 8'h60 |=> rdata[31:28] == 4'h0 && rdata[21:14] == 8'h0)
        else $error("reserved bits not zero");
    a_divisor_floor: assert property (rd && addr == 8'h60 ##1 !rdata[11] |-> rdata[26:23] >= 4'h3)
        else $error("divisor below floor");
    a_pll_pins: assert property (rd && addr == 8'h60 |=> {pll_power_down, pll_output_enable_n} == rdata[13:12])
        else $error("pll pins differ from register");
    a_reset_pll: assert property ($fell(reset) |-> pll_power_down && pll_output_enable_n)
        else $error("pll not held off after reset");
endmodule // clk_cfg_chk
bind run_clock_config_upper_fields clk_cfg_chk chk (.clock, .reset, .addr, .wr, .rd, .rdata, .power_mode,
    .run_gating_regs, .sleep_gating_regs, .deep_sleep_gating_regs, .periph_clock_enable, .pll_power_down,
    .pll_output_enable_n);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] power_mode = 2'h0;
    logic osc_tick = 1'b1;
    logic pll_tick = 1'b1;
    logic [31:0] rdata, pce, got;
    logic sys_clock_tick, pll_power_down, pll_output_enable_n, divider_active;
    logic [3:0] effective_divisor;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    run_clock_config_upper_fields uut (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata, .power_mode,
        .run_gating_regs(32'h0000_00a5), .sleep_gating_regs(32'h0000_5a00), .deep_sleep_gating_regs(32'h00c3_0000),
        .osc_tick, .pll_tick, .periph_clock_enable(pce), .sys_clock_tick, .pll_power_down, .pll_output_enable_n,
        .effective_divisor, .divider_active);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        got = rdata;
        @(posedge clock);
    endtask
    task automatic t_fields;
        rd_reg(8'h60);
        check(got, 32'h0780_3ad1);
        check(32'({pll_power_down, pll_output_enable_n, effective_divisor}), 32'h3f);
        wr_reg(8'h60, 32'hffff_ffff);
        rd_reg(8'h60);
        check(got, 32'h0fc0_3fff);
        rd_reg(8'h64);
        check(got, 32'h0);
        wr_reg(8'h60, 32'h0080_0000);
        rd_reg(8'h60);
        check(got, 32'h0180_0000);
        check(32'({pll_power_down, pll_output_enable_n, effective_divisor}), 32'h3);
        wr_reg(8'h60, 32'h0080_0800);
        rd_reg(8'h60);
        check(got, 32'h0080_0800);
    endtask
    task automatic t_gating;
        // Mode code 3 is not a sleep mode, so it must keep the run gating set.
        for (int g = 0; g < 8; g++) begin
            wr_reg(8'h60, 32'(g / 4) << 27);
            power_mode <= 2'(g % 4);
            repeat (2) @(posedge clock);
            rd_reg(8'h60);
            check(pce, (g == 5) ? 32'h5a00 : (g == 6) ? 32'h00c3_0000 : 32'h00a5);
        end
        power_mode <= 2'h0;
    endtask
    // The window is a whole number of divider periods, so the count is exact.
    task automatic t_ticks(input logic [31:0] cfg, input int n, input int exp);
        int cnt;
        cnt = 0;
        wr_reg(8'h60, cfg);
        repeat (8) @(posedge clock);
        repeat (n) begin
            @(negedge clock);
            cnt += int'(sys_clock_tick);
        end
        @(posedge clock);
        check(32'(cnt), 32'(exp));
        check(32'(divider_active), 32'(cfg[22] || !cfg[11]));
    endtask
    task wrap_up;
        if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_fields;
        t_gating;
        t_ticks(32'h0000_0800, 64, 64);
        t_ticks(32'h01c0_0800, 64, 16);
        t_ticks(32'h0200_0000, 60, 12);
        t_ticks(32'h0200_1000, 60, 0);
        wrap_up;
    end
endmodule // testbench
